/* File: rtl/scsc_top.sv */
// Reference selection, clock generation, sync skew, alarm I2C and shelf identity
`timescale 1ns/10ps
`default_nettype none
module scsc_top (
  input  wire logic                CLK_SYS,
  input  wire logic                RST_N,
  input  wire scsc_pkg::scsc_src_t SRC_SEL,
  input  wire logic                FORCE_SWAP,
  input  wire logic                REF_CC_PRI,
  input  wire logic                REF_CC_SEC,
  input  wire logic                REF_HS_PRI,
  input  wire logic                REF_HS_SEC,
  input  wire logic                LOCAL_OSC,
  input  wire logic                E1T1_DATA,
  input  wire logic                PEER_SYNC,
  input  wire logic                GO_ACTIVE,
  input  wire logic                FORCE_STANDBY,
  input  wire logic                STATUS_CLR,
  input  wire logic                ALARM_UPD_WE,
  input  wire logic [7:0]          ALARM_UPD_DATA,
  input  wire logic                ALARM_POLL,
  input  wire logic                SCL_I,
  input  wire logic                SDA_I,
  input  wire logic [7:0]          EXT_ALARM_IN,
  input  wire logic [7:0]          CUST_ALARM_IN,
  input  wire logic                SHELF_ID_SEND,
  input  wire logic [7:0]          SHELF_ADDR,
  input  wire logic [7:0]          SHELF_ID_DATA,
  output logic                     COMPOSITE_CLK,
  output logic                     HS_CLK,
  output logic                     TSC_SYNC,
  output logic                     ACTIVE,
  output logic                     USE_SEC_CC,
  output logic                     USE_SEC_HS,
  output logic [4:0]               REF_VALID,
  output logic                     REF_SWAP_FLAG,
  output logic                     REF_FAIL_FLAG,
  output logic                     TSC_SKEW_FLAG,
  output logic                     SCL_O,
  output logic                     SCL_OE,
  output logic                     SDA_O,
  output logic                     SDA_OE,
  output logic [7:0]               ALARM_STATUS,
  output logic                     ALARM_NACK,
  output logic                     ALARM_BUSY,
  output logic [7:0]               EXT_ALARM,
  output logic [7:0]               CUST_ALARM,
  output logic                     SHELF_TXD,
  output logic                     SHELF_BUSY
);
  import scsc_pkg::*;

  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : rise

  // Set wins over clear
  function automatic logic sticky(input logic flag, input logic set, input logic clr);
    return set | (flag & ~clr);
  endfunction : sticky

  logic [NUM_REF-1:0] ref_now;
  logic [NUM_REF-1:0] ref_prev;
  logic [8:0]         idle_cnt [NUM_REF];
  logic               fail_cc;
  logic               fail_hs;
  logic               swap_cc;
  logic               swap_hs;
  logic               cc_lvl;
  logic               hs_lvl;
  logic               hs_ok;
  logic [5:0]         bit_phase;
  logic [3:0]         der_div;
  logic               der_hs;
  logic               der_cc;
  logic               cc_src;
  logic               hs_src;
  logic               cc_src_prev;
  logic               cc_rise;
  logic [12:0]        tsc_cnt;
  logic               own_sync;
  logic               peer_prev;
  logic               peer_rise;
  logic [4:0]         since_own;
  logic [4:0]         since_peer;
  logic               skew_pend;
  logic               skew_evt;

  assign ref_now = {E1T1_DATA, REF_HS_SEC, REF_HS_PRI, REF_CC_SEC, REF_CC_PRI};

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ref_prev  <= '0;
      REF_VALID <= '0;
      for (int i = 0; i < NUM_REF; i++) begin
        idle_cnt[i] <= 9'h000;
      end
    end else begin
      ref_prev <= ref_now;
      for (int i = 0; i < NUM_REF; i++) begin
        if (ref_now[i] != ref_prev[i]) begin
          idle_cnt[i] <= 9'h000;
        end else if (idle_cnt[i] != 9'(REF_TIMEOUT_CYC)) begin
          idle_cnt[i] <= idle_cnt[i] + 9'h001;
        end
        REF_VALID[i] <= (idle_cnt[i] != 9'(REF_TIMEOUT_CYC));
      end
    end
  end

  assign fail_cc = USE_SEC_CC ? ~REF_VALID[REF_CC_S] : ~REF_VALID[REF_CC_P];
  assign fail_hs = USE_SEC_HS ? ~REF_VALID[REF_HS_S] : ~REF_VALID[REF_HS_P];
  // Only swap onto a healthy copy, otherwise both dead copies would thrash
  assign swap_cc = fail_cc & (USE_SEC_CC ? REF_VALID[REF_CC_P] : REF_VALID[REF_CC_S]);
  assign swap_hs = fail_hs & (USE_SEC_HS ? REF_VALID[REF_HS_P] : REF_VALID[REF_HS_S]);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      USE_SEC_CC    <= 1'b0;
      USE_SEC_HS    <= 1'b0;
      REF_SWAP_FLAG <= 1'b0;
      REF_FAIL_FLAG <= 1'b0;
    end else begin
      USE_SEC_CC    <= USE_SEC_CC ^ (FORCE_SWAP | swap_cc);
      USE_SEC_HS    <= USE_SEC_HS ^ (FORCE_SWAP | swap_hs);
      REF_SWAP_FLAG <= sticky(REF_SWAP_FLAG, swap_cc | swap_hs, STATUS_CLR);
      REF_FAIL_FLAG <= sticky(REF_FAIL_FLAG, fail_cc | fail_hs, STATUS_CLR);
    end
  end

  assign cc_lvl = USE_SEC_CC ? REF_CC_SEC : REF_CC_PRI;
  assign hs_lvl = USE_SEC_HS ? REF_HS_SEC : REF_HS_PRI;
  assign hs_ok  = ~fail_hs;

  // bit clock recovered from data transitions, composite by division
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      bit_phase <= 6'h00;
      der_div   <= 4'h0;
      der_hs    <= 1'b0;
      der_cc    <= 1'b0;
    end else begin
      if (ref_now[REF_DATA] != ref_prev[REF_DATA] || bit_phase == 6'(E1_BIT_CYC - 1)) begin
        bit_phase <= 6'h00;
      end else begin
        bit_phase <= bit_phase + 6'h01;
      end
      der_hs <= (bit_phase < 6'(E1_HALF_CYC));
      if (bit_phase == 6'h00) begin
        if (der_div == 4'(DER_CC_HALF - 1)) begin
          der_div <= 4'h0;
          der_cc  <= ~der_cc;
        end else begin
          der_div <= der_div + 4'h1;
        end
      end
    end
  end

  always_comb begin
    unique case (SRC_SEL)
      SRC_COMPOSITE, SRC_HIGHSPEED: begin
        cc_src = cc_lvl;
        hs_src = hs_lvl & hs_ok;
      end
      SRC_LOCAL: begin
        cc_src = LOCAL_OSC;
        hs_src = hs_lvl & hs_ok;
      end
      SRC_DERIVED: begin
        cc_src = der_cc;
        hs_src = der_hs;
      end
    endcase
  end

  assign cc_rise   = rise(cc_src, cc_src_prev);
  assign own_sync  = cc_rise && (tsc_cnt == 13'(TSC_EDGES - 1));
  assign peer_rise = rise(PEER_SYNC, peer_prev);
  assign skew_evt  = skew_pend && (since_peer == 5'(SKEW_WIN_CYC)) && !own_sync;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cc_src_prev   <= 1'b0;
      peer_prev     <= 1'b0;
      COMPOSITE_CLK <= 1'b0;
      HS_CLK        <= 1'b0;
      TSC_SYNC      <= 1'b0;
      tsc_cnt       <= 13'h0000;
    end else begin
      cc_src_prev <= cc_src;
      peer_prev   <= PEER_SYNC;
      // sync pulse inverts the composite output for one cycle
      COMPOSITE_CLK <= cc_src ^ TSC_SYNC;
      HS_CLK        <= hs_src;
      // standby card realigns its counter to the peer pulse
      TSC_SYNC      <= own_sync | (peer_rise & ~ACTIVE);
      if (peer_rise && !ACTIVE) begin
        tsc_cnt <= 13'h0000;
      end else if (cc_rise) begin
        tsc_cnt <= own_sync ? 13'h0000 : tsc_cnt + 13'h0001;
      end
    end
  end

  // peer pulse not matched by own pulse within the window is skew
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      since_own     <= 5'(SKEW_WIN_CYC);
      since_peer    <= 5'h00;
      skew_pend     <= 1'b0;
      TSC_SKEW_FLAG <= 1'b0;
    end else begin
      if (own_sync) begin
        since_own <= 5'h00;
      end else if (since_own != 5'(SKEW_WIN_CYC)) begin
        since_own <= since_own + 5'h01;
      end
      if (peer_rise && since_own == 5'(SKEW_WIN_CYC)) begin
        skew_pend  <= 1'b1;
        since_peer <= 5'h00;
      end else if (skew_pend) begin
        since_peer <= since_peer + 5'h01;
        if (own_sync || since_peer == 5'(SKEW_WIN_CYC)) begin
          skew_pend <= 1'b0;
        end
      end
      TSC_SKEW_FLAG <= sticky(TSC_SKEW_FLAG, skew_evt, STATUS_CLR);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ACTIVE <= 1'b0;
    end else if (FORCE_STANDBY) begin
      ACTIVE <= 1'b0;
    end else if (GO_ACTIVE) begin
      ACTIVE <= 1'b1;
    end
  end

  // separate external and customer alarm registers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      EXT_ALARM  <= 8'h00;
      CUST_ALARM <= 8'h00;
    end else begin
      EXT_ALARM  <= EXT_ALARM_IN;
      CUST_ALARM <= CUST_ALARM_IN;
    end
  end

  scsc_i2c_t   i2c_state;
  logic [8:0]  qtr_cnt;
  logic        qtr_tick;
  logic [1:0]  phase;
  logic [4:0]  i2c_bit;
  logic [17:0] i2c_sh;
  logic        i2c_read;
  logic        samp;
  logic        upd_pend;
  logic        read_due;
  logic [7:0]  upd_data;
  logic        take_upd;
  logic        take_read;

  assign qtr_tick  = (qtr_cnt == 9'(I2C_QTR_CYC - 1));
  assign take_upd  = (i2c_state == I2C_IDLE) && qtr_tick && upd_pend;
  assign take_read = (i2c_state == I2C_IDLE) && qtr_tick && !upd_pend && read_due;

  // update write latched and queued for the alarm card
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      upd_pend <= 1'b0;
      upd_data <= 8'h00;
      read_due <= 1'b0;
    end else begin
      if (ALARM_UPD_WE) begin
        upd_data <= ALARM_UPD_DATA;
      end
      upd_pend <= sticky(upd_pend, ALARM_UPD_WE, take_upd);
      read_due <= sticky(read_due, ALARM_POLL ||
                  (i2c_state == I2C_STOP && qtr_tick && phase == 2'd3 && !i2c_read), take_read);
    end
  end

  // I2C master, four quarter phases per bit, open drain
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      i2c_state    <= I2C_IDLE;
      qtr_cnt      <= 9'h000;
      phase        <= 2'd0;
      i2c_bit      <= 5'h00;
      i2c_sh       <= '1;
      i2c_read     <= 1'b0;
      samp         <= 1'b1;
      SCL_O        <= 1'b0;
      SDA_O        <= 1'b0;
      SCL_OE       <= 1'b0;
      SDA_OE       <= 1'b0;
      ALARM_STATUS <= 8'h00;
      ALARM_NACK   <= 1'b0;
      ALARM_BUSY   <= 1'b0;
    end else begin
      qtr_cnt    <= qtr_tick ? 9'h000 : qtr_cnt + 9'h001;
      ALARM_BUSY <= (i2c_state != I2C_IDLE) || upd_pend || read_due;
      ALARM_NACK <= sticky(ALARM_NACK, i2c_state == I2C_BITS && qtr_tick && phase == 2'd2 &&
                    SDA_I && (i2c_bit == 5'(I2C_ACK1_BIT) ||
                    (i2c_bit == 5'(I2C_LAST_BIT) && !i2c_read)), STATUS_CLR);
      if (qtr_tick) begin
        phase <= phase + 2'd1;
        unique case (i2c_state)
          I2C_IDLE: begin
            phase  <= 2'd0;
            SCL_OE <= 1'b0;
            SDA_OE <= 1'b0;
            if (take_upd || take_read) begin
              i2c_read  <= take_read;
              i2c_sh    <= take_read ? {ALARM_DEV_ADDR, 1'b1, 1'b1, 8'hff, 1'b1}
                                     : {ALARM_DEV_ADDR, 1'b0, 1'b1, upd_data, 1'b1};
              i2c_bit   <= 5'h00;
              i2c_state <= I2C_START;
            end
          end
          I2C_START: begin
            if (phase == 2'd1) begin
              SDA_OE <= 1'b1;
            end
            if (phase == 2'd2) begin
              SCL_OE <= 1'b1;
            end
            if (phase == 2'd3) begin
              i2c_state <= I2C_BITS;
            end
          end
          I2C_BITS: begin
            unique case (phase)
              2'd0: SDA_OE <= ~i2c_sh[17];
              2'd1: SCL_OE <= 1'b0;
              2'd2: samp   <= SDA_I;
              2'd3: begin
                SCL_OE  <= 1'b1;
                i2c_sh  <= {i2c_sh[16:0], samp};
                i2c_bit <= i2c_bit + 5'h01;
                if (i2c_bit == 5'(I2C_LAST_BIT)) begin
                  i2c_state <= I2C_STOP;
                end
              end
            endcase
          end
          I2C_STOP: begin
            unique case (phase)
              2'd0: SDA_OE <= 1'b1;
              2'd1: SCL_OE <= 1'b0;
              2'd2: SDA_OE <= 1'b0;
              2'd3: begin
                // status read back from the alarm card
                if (i2c_read) begin
                  ALARM_STATUS <= i2c_sh[8:1];
                end
                i2c_state <= I2C_IDLE;
              end
            endcase
          end
        endcase
      end
    end
  end

  scsc_shelf_t sh_state;
  logic [7:0]  sh_data;
  logic [8:0]  u_data;
  logic        u_start;
  logic        u_busy;

  // processor-chosen target shelf sent ahead of the identity
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sh_state   <= SH_IDLE;
      sh_data    <= 8'h00;
      u_data     <= 9'h000;
      u_start    <= 1'b0;
      SHELF_BUSY <= 1'b0;
    end else begin
      u_start    <= 1'b0;
      SHELF_BUSY <= (sh_state != SH_IDLE);
      unique case (sh_state)
        SH_IDLE: begin
          if (SHELF_ID_SEND) begin
            // ninth bit marks the address character
            u_data   <= {1'b1, SHELF_ADDR};
            sh_data  <= SHELF_ID_DATA;
            sh_state <= SH_ADDR;
          end
        end
        SH_ADDR: begin
          if (!u_busy && !u_start) begin
            u_start  <= 1'b1;
            sh_state <= SH_DATA;
          end
        end
        SH_DATA: begin
          if (!u_busy && !u_start) begin
            u_data   <= {1'b0, sh_data};
            u_start  <= 1'b1;
            sh_state <= SH_LAST;
          end
        end
        SH_LAST: begin
          if (!u_busy && !u_start) begin
            sh_state <= SH_IDLE;
          end
        end
      endcase
    end
  end

  scsc_uart9 u_uart (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .start (u_start),
    .data  (u_data),
    .txd   (SHELF_TXD),
    .busy  (u_busy)
  );

endmodule : scsc_top
`default_nettype wire

/* File: rtl/scsc_pkg.sv */
// Constants and types for the system clock select and control block
package scsc_pkg;

  localparam int SYS_PERIOD_NS   = 8;
  localparam int REF_TIMEOUT_NS  = 2000;
  localparam int REF_TIMEOUT_CYC = REF_TIMEOUT_NS / SYS_PERIOD_NS;
  localparam int E1_BIT_NS       = 488;
  localparam int E1_BIT_CYC      = E1_BIT_NS / SYS_PERIOD_NS;
  localparam int E1_HALF_CYC     = E1_BIT_CYC / 2;
  localparam int DER_CC_HALF     = 16;
  localparam int TSC_EDGES       = 8000;
  localparam int SKEW_WIN_NS     = 128;
  localparam int SKEW_WIN_CYC    = SKEW_WIN_NS / SYS_PERIOD_NS;
  localparam int I2C_QTR_NS      = 2500;
  localparam int I2C_QTR_CYC     = (I2C_QTR_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int UART_BIT_NS     = 8680;
  localparam int UART_BIT_CYC    = UART_BIT_NS / SYS_PERIOD_NS;

  localparam int NUM_REF  = 5;
  localparam int REF_CC_P = 0;
  localparam int REF_CC_S = 1;
  localparam int REF_HS_P = 2;
  localparam int REF_HS_S = 3;
  localparam int REF_DATA = 4;

  localparam logic [6:0] ALARM_DEV_ADDR = 7'h20;
  localparam int         I2C_LAST_BIT   = 17;
  localparam int         I2C_ACK1_BIT   = 8;
  localparam int         UART_LAST_BIT  = 10;

  typedef enum logic [1:0] {SRC_COMPOSITE, SRC_HIGHSPEED, SRC_LOCAL, SRC_DERIVED} scsc_src_t;
  typedef enum logic [1:0] {I2C_IDLE, I2C_START, I2C_BITS, I2C_STOP} scsc_i2c_t;
  typedef enum logic [1:0] {SH_IDLE, SH_ADDR, SH_DATA, SH_LAST} scsc_shelf_t;

endpackage : scsc_pkg

/* File: rtl/scsc_uart9.sv */
// Transmit-only UART with 9-bit characters, one start and one stop bit
`timescale 1ns/10ps
`default_nettype none
module scsc_uart9 (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [8:0] data,
  output logic            txd,
  output logic            busy
);
  import scsc_pkg::*;

  logic [10:0] shreg;
  logic [3:0]  bit_idx;
  logic [10:0] baud_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg    <= 11'h7ff;
      bit_idx  <= 4'h0;
      baud_cnt <= 11'h000;
      busy     <= 1'b0;
      txd      <= 1'b1;
    end else if (!busy) begin
      txd <= 1'b1;
      // start, nine data bits LSB first, stop
      if (start) begin
        shreg    <= {1'b1, data, 1'b0};
        bit_idx  <= 4'h0;
        baud_cnt <= 11'h000;
        busy     <= 1'b1;
      end
    end else begin
      txd <= shreg[0];
      if (baud_cnt == 11'(UART_BIT_CYC - 1)) begin
        baud_cnt <= 11'h000;
        shreg    <= {1'b1, shreg[10:1]};
        bit_idx  <= bit_idx + 4'h1;
        if (bit_idx == 4'(UART_LAST_BIT)) begin
          busy <= 1'b0;
        end
      end else begin
        baud_cnt <= baud_cnt + 11'h001;
      end
    end
  end

endmodule : scsc_uart9
`default_nettype wire

/* File: tb/scsc_top_monitor.sv */
// Port checker for the system clock select and control block
`timescale 1ns/10ps
`default_nettype none
module scsc_mon (
  input wire logic                CLK_SYS,
  input wire logic                RST_N,
  input wire scsc_pkg::scsc_src_t SRC_SEL,
  input wire logic                FORCE_SWAP,
  input wire logic                FORCE_STANDBY,
  input wire logic                STATUS_CLR,
  input wire logic                REF_CC_PRI,
  input wire logic                REF_HS_PRI,
  input wire logic                REF_HS_SEC,
  input wire logic                PEER_SYNC,
  input wire logic                HS_CLK,
  input wire logic                TSC_SYNC,
  input wire logic                ACTIVE,
  input wire logic                USE_SEC_CC,
  input wire logic                USE_SEC_HS,
  input wire logic [4:0]          REF_VALID,
  input wire logic                REF_SWAP_FLAG,
  input wire logic                SCL_OE,
  input wire logic                SDA_OE,
  input wire logic                SHELF_BUSY,
  input wire logic                SHELF_TXD
);
  import scsc_pkg::*;
  logic [8:0] idle;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // Saturates well past the timeout so it never wraps
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N)
      idle <= 9'h000;
    else if (REF_CC_PRI != $past(REF_CC_PRI))
      idle <= 9'h000;
    else if (idle < 9'h12c)
      idle <= idle + 9'h001;
  end
  sequence s_lost;
    $fell(REF_VALID[0]) && !USE_SEC_CC && REF_VALID[1];
  endsequence
  sequence s_start;
    $rose(SDA_OE) && !SCL_OE;
  endsequence
  a_valid_lost: assert property (idle >= 9'h0ff |-> !REF_VALID[0])
    else $error("idle copy still valid");
  a_valid_early: assert property ($fell(REF_VALID[0]) |-> idle >= 9'h0f8)
    else $error("copy invalid too early");
  a_auto_swap: assert property (s_lost |-> ##[1:2] (USE_SEC_CC && REF_SWAP_FLAG))
    else $error("no automatic swap");
  a_flag_hold: assert property (REF_SWAP_FLAG && !STATUS_CLR |=> REF_SWAP_FLAG)
    else $error("swap flag lost");
  a_force_swap: assert property (FORCE_SWAP |=> USE_SEC_HS != $past(USE_SEC_HS))
    else $error("forced swap ignored");
  a_hs_follow: assert property ((SRC_SEL == SRC_HIGHSPEED && $stable(SRC_SEL) &&
    REF_VALID[3:2] == 2'h3 && $past(REF_VALID[3:2]) == 2'h3)
    |-> HS_CLK == $past(USE_SEC_HS ? REF_HS_SEC : REF_HS_PRI))
    else $error("high-speed clock not forwarded");
  a_standby: assert property (FORCE_STANDBY |=> !ACTIVE)
    else $error("still active");
  a_sync_pulse: assert property (TSC_SYNC |=> !TSC_SYNC)
    else $error("sync pulse too long");
  a_peer_align: assert property (!ACTIVE && $rose(PEER_SYNC) |-> ##[1:3] TSC_SYNC)
    else $error("standby sync not aligned");
  a_i2c_start: assert property (s_start |-> ##[300:330] $rose(SCL_OE))
    else $error("bad start condition");
  a_shelf_start: assert property ($rose(SHELF_BUSY) |-> ##[0:4] !SHELF_TXD)
    else $error("no start bit");
endmodule : scsc_mon

bind scsc_top scsc_mon scsc_mon_inst (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .SRC_SEL(SRC_SEL), .FORCE_SWAP(FORCE_SWAP),
  .FORCE_STANDBY(FORCE_STANDBY), .STATUS_CLR(STATUS_CLR), .REF_CC_PRI(REF_CC_PRI),
  .REF_HS_PRI(REF_HS_PRI), .REF_HS_SEC(REF_HS_SEC), .PEER_SYNC(PEER_SYNC), .HS_CLK(HS_CLK),
  .TSC_SYNC(TSC_SYNC), .ACTIVE(ACTIVE), .USE_SEC_CC(USE_SEC_CC), .USE_SEC_HS(USE_SEC_HS),
  .REF_VALID(REF_VALID), .REF_SWAP_FLAG(REF_SWAP_FLAG), .SCL_OE(SCL_OE), .SDA_OE(SDA_OE),
  .SHELF_BUSY(SHELF_BUSY), .SHELF_TXD(SHELF_TXD)
);
`default_nettype wire

/* File: tb/scsc_card.sv */
// Behavioural alarm card acting as I2C target
`timescale 1ns/10ps
`default_nettype none
module scsc_card #(
  parameter logic [7:0] STATUS_BYTE = 8'h5a
) (
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            pull,
  output logic [7:0]      wr_byte
);
  import scsc_pkg::*;
  logic [7:0] sh;
  task automatic get_byte();
    repeat (8) begin
      @(posedge scl);
      sh = {sh[6:0], sda};
    end
  endtask : get_byte
  task automatic ack();
    @(negedge scl);
    pull = 1'b1;
    @(negedge scl);
  endtask : ack
  initial begin
    pull = 1'b0;
    wr_byte = 8'h00;
    forever begin
      @(negedge sda iff scl);
      get_byte();
      if (sh[7:1] == ALARM_DEV_ADDR) begin
        ack();
        if (sh[0]) begin
          // Data changes only while the clock is low
          for (int i = 7; i >= 0; i--) begin
            pull = ~STATUS_BYTE[i];
            @(negedge scl);
          end
        end else begin
          pull = 1'b0;
          get_byte();
          wr_byte = sh;
          ack();
        end
        pull = 1'b0;
      end
    end
  end
endmodule : scsc_card
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking testbench for the system clock select and control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import scsc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, tog = 1'b0, e1 = 1'b0, force_swap = 1'b0;
  logic peer = 1'b0, go_act = 1'b0, stby = 1'b0, clr = 1'b0, upd_we = 1'b0;
  logic poll = 1'b0, send = 1'b0;
  logic [4:0] ref_en = 5'h1f;
  logic [7:0] upd_data = 8'h00, ext_in = 8'h00, cust_in = 8'h00;
  logic [7:0] sh_addr = 8'h00, sh_data = 8'h00;
  scsc_src_t  src_sel = SRC_COMPOSITE;
  logic cc_clk, hs_clk, tsc_sync, active, sec_cc, sec_hs, swap_f, fail_f, skew_f;
  logic nack, busy, scl_o, scl_oe, sda_o, sda_oe, txd, sh_busy, pull;
  logic [4:0] valid;
  logic [7:0] status, ext_al, cust_al, wr_byte;
  logic [10:0] ch;
  wire        scl = ~scl_oe;
  wire        sda = ~(sda_oe | pull);
  int         e1_cnt = 0, n_mismatch = 0, checks_done = 0, nh, nc;

  scsc_top scsc_top_inst (
    .CLK_SYS(clk), .RST_N(rst_n), .SRC_SEL(src_sel), .FORCE_SWAP(force_swap),
    .REF_CC_PRI(tog & ref_en[0]), .REF_CC_SEC(tog & ref_en[1]), .REF_HS_PRI(tog & ref_en[2]),
    .REF_HS_SEC(tog & ref_en[3]), .LOCAL_OSC(tog), .E1T1_DATA(e1), .PEER_SYNC(peer),
    .GO_ACTIVE(go_act), .FORCE_STANDBY(stby), .STATUS_CLR(clr), .ALARM_UPD_WE(upd_we),
    .ALARM_UPD_DATA(upd_data), .ALARM_POLL(poll), .SCL_I(scl), .SDA_I(sda),
    .EXT_ALARM_IN(ext_in), .CUST_ALARM_IN(cust_in), .SHELF_ID_SEND(send),
    .SHELF_ADDR(sh_addr), .SHELF_ID_DATA(sh_data), .COMPOSITE_CLK(cc_clk), .HS_CLK(hs_clk),
    .TSC_SYNC(tsc_sync), .ACTIVE(active), .USE_SEC_CC(sec_cc), .USE_SEC_HS(sec_hs),
    .REF_VALID(valid), .REF_SWAP_FLAG(swap_f), .REF_FAIL_FLAG(fail_f),
    .TSC_SKEW_FLAG(skew_f), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .ALARM_STATUS(status), .ALARM_NACK(nack), .ALARM_BUSY(busy),
    .EXT_ALARM(ext_al), .CUST_ALARM(cust_al), .SHELF_TXD(txd), .SHELF_BUSY(sh_busy)
  );
  scsc_card #(.STATUS_BYTE(8'h5a)) scsc_card_inst (
    .scl(scl), .sda(sda), .pull(pull), .wr_byte(wr_byte)
  );

  always #4 clk = ~clk;
  // References toggle every cycle; the data stream once per bit time
  always @(negedge clk) begin
    tog <= ~tog;
    e1_cnt <= (e1_cnt == E1_BIT_CYC - 1) ? 0 : e1_cnt + 1;
    if (e1_cnt == 0)
      e1 <= ~e1;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic timeout(input string what);
    n_mismatch++;
    $display("wrong value at %0t: %s timed out", $time, what);
    summarize();
  endtask : timeout
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  task automatic count(input int n);
    logic ph, pc;
    nh = 0;
    nc = 0;
    repeat (n) begin
      ph = hs_clk;
      pc = cc_clk;
      cyc(1);
      if (hs_clk !== ph) nh++;
      if (cc_clk !== pc) nc++;
    end
  endtask : count
  // Samples one 11-bit character mid-bit, start bit ends in bit 0
  task automatic get_char();
    int k;
    k = 0;
    while (txd !== 1'b0) begin
      cyc(1);
      k++;
      if (k > 3000) timeout("start bit");
    end
    cyc(542);
    for (int b = 0; b < 11; b++) begin
      ch = {txd, ch[10:1]};
      if (b < 10) cyc(1085);
    end
  endtask : get_char

  task automatic test_refs();
    cyc(10);
    check(valid, 5'h1f, "copies valid");
    ref_en[0] = 1'b0;
    cyc(260);
    check({valid[0], sec_cc, swap_f, fail_f}, 4'h7, "auto swap");
    ref_en[0] = 1'b1;
    cyc(4);
    pulse(clr);
    cyc(2);
    check({swap_f, fail_f}, 2'h0, "flags cleared");
    pulse(force_swap);
    cyc(2);
    check({sec_cc, sec_hs}, 2'h1, "forced swap");
    $display("test refs done");
  endtask : test_refs
  task automatic test_clocks();
    count(200);
    check(nc > 50, 1'b1, "composite runs");
    src_sel = SRC_HIGHSPEED;
    count(200);
    check(nh > 50, 1'b1, "high-speed runs");
    ref_en[3:2] = 2'h0;
    src_sel = SRC_LOCAL;
    cyc(300);
    count(400);
    check({nh == 0, nc > 50}, 2'h3, "local osc");
    ref_en = 5'h1f;
    src_sel = SRC_DERIVED;
    cyc(300);
    count(4200);
    check({nh > 10, nc > 0}, 2'h3, "derived clocks");
    src_sel = SRC_COMPOSITE;
    $display("test clocks done");
  endtask : test_clocks
  task automatic test_tsc();
    int n;
    pulse(go_act);
    cyc(1);
    check(active, 1'b1, "active");
    peer = 1'b1;
    cyc(30);
    check(skew_f, 1'b1, "skew seen");
    peer = 1'b0;
    pulse(stby);
    cyc(1);
    check(active, 1'b0, "standby");
    pulse(clr);
    cyc(2);
    n = 0;
    peer = 1'b1;
    repeat (6) begin
      cyc(1);
      if (tsc_sync === 1'b1) n++;
    end
    check(n == 1, 1'b1, "one sync");
    cyc(30);
    // Realigning to an unmatched peer pulse is itself a skew event
    check(skew_f, 1'b1, "realign skew reported");
    peer = 1'b0;
    $display("test tsc done");
  endtask : test_tsc
  task automatic test_alarm();
    int n, k;
    ext_in = 8'ha5;
    cust_in = 8'h3c;
    cyc(2);
    check({ext_al, cust_al}, 16'ha53c, "opto alarms");
    upd_data = 8'h96;
    upd_we = 1'b1;
    poll = 1'b1;
    cyc(1);
    upd_we = 1'b0;
    poll = 1'b0;
    n = 0;
    k = 0;
    // Idle must persist longer than one bus phase
    while (n < 700) begin
      cyc(1);
      k++;
      n = (busy === 1'b0) ? n + 1 : 0;
      if (k > 70000) timeout("alarm bus");
    end
    check(wr_byte, 8'h96, "update sent");
    check({status, nack, scl_o, sda_o}, 11'h2d0, "status read");
    $display("test alarm done");
  endtask : test_alarm
  task automatic test_shelf();
    int n;
    sh_addr = 8'h12;
    sh_data = 8'hc3;
    pulse(send);
    cyc(20);
    check(sh_busy, 1'b1, "shelf busy");
    sh_addr = 8'h7e;
    pulse(send);
    get_char();
    check(ch, 11'h624, "address char");
    get_char();
    check(ch, 11'h586, "data char");
    n = 0;
    repeat (2500) begin
      cyc(1);
      if (txd !== 1'b1) n++;
    end
    check(n == 0, 1'b1, "busy send ignored");
    $display("test shelf done");
  endtask : test_shelf

  initial begin
    cyc(6);
    check({valid, active, sec_cc, sec_hs, swap_f, fail_f, skew_f, nack, txd}, 13'h1, "reset");
    rst_n = 1'b1;
    test_refs();
    test_clocks();
    test_tsc();
    test_alarm();
    test_shelf();
    summarize();
  end
endmodule : tb
`default_nettype wire
